// ---- pkg/readout_pkg.sv ----
// Constants, field layouts and carrier types of the image readout sequencer.
// Assumes a 50 MHz system clock and a separate output link clock.
package readout_pkg;

   // ----------------------------------------------------------------
   // Clocks and time figures
   // ----------------------------------------------------------------
   localparam int CLK_NS = 20;
   localparam int LINK_NS = 30;
   localparam int PIX_READ_NS = 2000;
   localparam int CONV8_NS = 1000;
   localparam int CONV10_NS = 1500;
   localparam int CONV12_NS = 2500;
   localparam int CONV14_NS = 4000;
   localparam logic [15:0] PIX_READ_CYC = 16'((PIX_READ_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] CONV8_CYC = 16'((CONV8_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] CONV10_CYC = 16'((CONV10_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] CONV12_CYC = 16'((CONV12_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] CONV14_CYC = 16'((CONV14_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] CROSS_MARGIN_CYC = 16'h0004;

   // ----------------------------------------------------------------
   // Register write addresses (reads use the even address below)
   // ----------------------------------------------------------------
   localparam logic [15:0] ADDR_ROI_Y = 16'h0001;
   localparam logic [15:0] ADDR_ROI_H = 16'h0009;
   localparam logic [15:0] ADDR_ROI_W = 16'h0019;
   localparam logic [15:0] ADDR_VERTICAL_BLANK = 16'h0089;
   localparam logic [15:0] ADDR_INTEG = 16'h0091;
   localparam logic [15:0] ADDR_MODE = 16'h01d1;
   localparam logic [15:0] ADDR_STATE = 16'h4019;

   localparam logic [15:0] RST_ROI_Y = 16'h0000;
   localparam logic [15:0] RST_ROI_H = 16'h0860;
   localparam logic [15:0] RST_ROI_W = 16'h0b20;
   localparam logic [15:0] RST_VERTICAL_BLANK = 16'h0000;
   localparam logic [15:0] RST_INTEG = 16'h0d66;
   localparam logic [15:0] RST_MODE = 16'h0000;
   localparam logic [15:0] RST_STATE = 16'h0000;
   localparam logic [15:0] RUN_STATE_CODE = 16'h0003;

   // ----------------------------------------------------------------
   // Readout mode fields
   // ----------------------------------------------------------------
   localparam int MODE_SHUTTER_LSB = 0;
   localparam int MODE_SCAN_BIT = 2;
   localparam int MODE_DEPTH_LSB = 3;
   localparam int MODE_BANKS_LSB = 5;
   localparam logic [1:0] SHUTTER_GLOBAL = 2'h0;
   localparam logic [1:0] SHUTTER_ROLLING = 2'h1;
   localparam logic [1:0] DEPTH_10 = 2'h0;
   localparam logic [1:0] DEPTH_12 = 2'h1;
   localparam logic [1:0] DEPTH_14 = 2'h2;
   localparam logic [1:0] DEPTH_8 = 2'h3;
   localparam logic [1:0] BANKS_8 = 2'h0;
   localparam logic [1:0] BANKS_4 = 2'h1;
   localparam logic [1:0] BANKS_2 = 2'h2;

   // ----------------------------------------------------------------
   // Output link
   // ----------------------------------------------------------------
   localparam int NUM_BANKS = 8;
   localparam int NUM_PAIRS = 7;
   localparam int PIX_W = 14;
   localparam logic [15:0] SYNC_LEN = 16'h0004;
   localparam logic [13:0] SYNC_LEAD = 14'h3fff;
   localparam logic [13:0] CODE_SOF = 14'h0200;
   localparam logic [13:0] CODE_SOL = 14'h0280;
   localparam logic [13:0] CODE_EOF = 14'h0240;
   localparam logic [13:0] CODE_EOL = 14'h02c0;

   typedef struct packed {
      logic strobe;
      logic [15:0] addr;
      logic [15:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [NUM_PAIRS-1:0] msb;
      logic [NUM_PAIRS-1:0] lsb;
      logic [NUM_PAIRS-1:0] en;
   } bank_out_t;

   typedef struct packed {
      logic first;
      logic last;
      logic [1:0] depth;
      logic [1:0] banks;
      logic [15:0] words;
   } line_msg_t;

   typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_t;
   typedef enum logic [1:0] {LNK_IDLE, LNK_HEAD, LNK_PIX, LNK_TAIL} lnk_t;

endpackage : readout_pkg

// ---- hdl/image_readout_sequencer.sv ----
// Frame and line sequencer of the image sensor with its eight-bank output link.
// Assumes the register port is synchronous to clk_i and the pixel source runs on link_clk_i.
`timescale 1ns/1ps

module image_readout_sequencer import readout_pkg::*; (
   // System clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register port
   input wire reg_req_t reg_req_i,
   output logic [15:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // Frame trigger pin
   input wire logic frame_trigger_i,
   // Array control
   output logic run_state_o,
   output logic integ_all_o,
   output logic row_reset_o,
   output logic [15:0] row_reset_addr_o,
   output logic row_read_o,
   output logic [15:0] row_read_addr_o,
   // Output link
   input wire logic link_clk_i,
   input wire logic [NUM_BANKS-1:0][PIX_W-1:0] pix_i,
   output logic pix_take_o,
   output logic bank_valid_o,
   output bank_out_t [NUM_BANKS-1:0] bank_o
);

   typedef struct packed {
      seq_t st;
      logic [15:0] roi_y;
      logic [15:0] roi_h;
      logic [15:0] roi_w;
      logic [15:0] vertical_blank;
      logic [15:0] integ;
      logic [15:0] mode;
      logic [15:0] cmd;
      logic [1:0] trig_sync;
      logic [15:0] rdata;
      logic rvalid;
      logic [15:0] line_cyc;
      logic [15:0] frame_len;
      logic [15:0] lcnt;
      logic [15:0] line;
      logic armed;
      logic rd_en;
      logic integ_all;
      logic row_reset;
      logic [15:0] row_reset_addr;
      logic row_read;
      logic [15:0] row_read_addr;
      logic tog;
      line_msg_t msg;
   } sys_state_t;

   typedef struct packed {
      lnk_t st;
      logic [2:0] tog_sync;
      line_msg_t msg;
      logic [15:0] cnt;
      logic valid;
      logic take;
      bank_out_t [NUM_BANKS-1:0] bank;
   } link_state_t;

   sys_state_t s_reg, s_next;
   link_state_t l_reg, l_next;
   logic [1:0] lrst_q;

   logic [1:0] depth_c;
   logic [1:0] banks_c;
   logic [15:0] ro_c;
   logic [15:0] integ_c;
   logic [15:0] int_start_c;
   logic [15:0] words_c;
   logic [15:0] conv_c;
   logic [15:0] rc_c;
   logic [15:0] tx_c;
   logic [31:0] tx_wide_c;
   logic [16:0] ro_vb_c;
   logic [15:0] need_c;
   logic [15:0] frame_len_c;
   logic [15:0] line_cyc_c;
   logic [16:0] rs_wide_c;
   logic [15:0] rs_c;
   logic run_c;
   logic rolling_c;
   logic line_end_c;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] max16(input logic [15:0] a, input logic [15:0] b);
      return (a > b) ? a : b;
   endfunction : max16

   function automatic logic [15:0] read_mux(input sys_state_t s, input logic [15:0] waddr);
      logic [15:0] r;
      r = 16'h0000;
      unique case (waddr)
         ADDR_ROI_Y: r = s.roi_y;
         ADDR_ROI_H: r = s.roi_h;
         ADDR_ROI_W: r = s.roi_w;
         ADDR_VERTICAL_BLANK: r = s.vertical_blank;
         ADDR_INTEG: r = s.integ;
         ADDR_MODE: r = s.mode;
         ADDR_STATE: r = (s.st == SEQ_RUN) ? RUN_STATE_CODE : s.cmd;
         default: r = 16'h0000;
      endcase
      return r;
   endfunction : read_mux

   // Splits one word into the two DDR halves; unused pairs are disabled (high impedance)
   function automatic bank_out_t drive(input logic [PIX_W-1:0] word, input logic [1:0] depth,
                                       input logic active);
      bank_out_t b;
      logic [2:0] half;
      logic [NUM_PAIRS-1:0] mask;
      half = 3'h5;
      unique case (depth)
         DEPTH_8: half = 3'h4;
         DEPTH_10: half = 3'h5;
         DEPTH_12: half = 3'h6;
         DEPTH_14: half = 3'h7;
      endcase
      mask = 7'((8'h01 << half) - 8'h01);
      b.msb = 7'(word >> half) & mask;
      b.lsb = word[NUM_PAIRS-1:0] & mask;
      b.en = active ? mask : 7'h00;
      return b;
   endfunction : drive

   // ----------------------------------------------------------------
   // Line and frame timing
   // ----------------------------------------------------------------
   assign depth_c = s_reg.mode[MODE_DEPTH_LSB +: 2];
   assign banks_c = s_reg.mode[MODE_BANKS_LSB +: 2];
   assign rolling_c = (s_reg.mode[MODE_SHUTTER_LSB +: 2] == SHUTTER_ROLLING);
   assign run_c = (s_reg.cmd == RUN_STATE_CODE) || s_reg.trig_sync[1];
   // Height counts row pairs; bit 0 is dropped so the region stays even
   assign ro_c = (s_reg.roi_h[15:1] == 15'h0000) ? 16'h0001 :
                 {1'b0, s_reg.roi_h[15:1]};
   assign integ_c = (s_reg.integ == 16'h0000) ? 16'h0001 : s_reg.integ;
   // Each converter feeds half of the active banks
   assign words_c = (banks_c == BANKS_2) ? s_reg.roi_w :
                    (banks_c == BANKS_4) ? {1'b0, s_reg.roi_w[15:1]} :
                    {2'b00, s_reg.roi_w[15:2]};
   assign conv_c = (depth_c == DEPTH_8) ? CONV8_CYC : (depth_c == DEPTH_12) ? CONV12_CYC :
                   (depth_c == DEPTH_14) ? CONV14_CYC : CONV10_CYC;
   assign rc_c = PIX_READ_CYC + conv_c;
   // Transmit time covers pixels plus both sync groups, rounded up to system cycles
   assign tx_wide_c = ((32'(words_c) + 32'(2 * SYNC_LEN)) * 32'(LINK_NS) + 32'(CLK_NS - 1))
                      / 32'(CLK_NS);
   assign tx_c = tx_wide_c[15:0] + CROSS_MARGIN_CYC;
   assign line_cyc_c = s_reg.mode[MODE_SCAN_BIT] ?
                       max16(max16(PIX_READ_CYC, conv_c), tx_c) :
                       max16(tx_c, rc_c);
   assign ro_vb_c = {1'b0, ro_c} + {1'b0, s_reg.vertical_blank};
   assign need_c = ro_vb_c[16] ? 16'hffff : ro_vb_c[15:0];
   assign frame_len_c = max16(need_c, integ_c);
   // Integration is placed at the end of the period so it ends as readout starts
   assign int_start_c = s_reg.frame_len -
                        ((integ_c > s_reg.frame_len) ? s_reg.frame_len : integ_c);
   assign line_end_c = (s_reg.lcnt >= s_reg.line_cyc - 16'h0001);
   assign rs_wide_c = {1'b0, s_reg.line} + {1'b0, integ_c};
   assign rs_c = (rs_wide_c >= {1'b0, s_reg.frame_len}) ? 16'(rs_wide_c - {1'b0, s_reg.frame_len})
                 : rs_wide_c[15:0];

   // ----------------------------------------------------------------
   // System domain next state
   // ----------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.trig_sync = {s_reg.trig_sync[0], frame_trigger_i};
      s_next.rvalid = 1'b0;
      s_next.row_reset = 1'b0;
      s_next.row_read = 1'b0;
      s_next.line_cyc = line_cyc_c;
      s_next.frame_len = frame_len_c;
      if (reg_req_i.strobe && reg_req_i.addr[0]) begin
         case (reg_req_i.addr)
            ADDR_ROI_Y: s_next.roi_y = reg_req_i.wdata;
            ADDR_ROI_H: s_next.roi_h = reg_req_i.wdata;
            ADDR_ROI_W: s_next.roi_w = reg_req_i.wdata;
            ADDR_VERTICAL_BLANK: s_next.vertical_blank = reg_req_i.wdata;
            ADDR_INTEG: s_next.integ = reg_req_i.wdata;
            ADDR_MODE: s_next.mode = reg_req_i.wdata;
            ADDR_STATE: s_next.cmd = reg_req_i.wdata;
            default: ;
         endcase
      end else if (reg_req_i.strobe) begin
         s_next.rvalid = 1'b1;
         s_next.rdata = read_mux(s_reg, {reg_req_i.addr[15:1], 1'b1});
      end
      unique case (s_reg.st)
         SEQ_IDLE: begin
            s_next.integ_all = 1'b0;
            if (run_c) begin
               s_next.st = SEQ_RUN;
               s_next.line = int_start_c;
               s_next.lcnt = 16'h0000;
               s_next.armed = 1'b0;
               s_next.rd_en = 1'b0;
            end
         end
         SEQ_RUN: begin
            s_next.lcnt = line_end_c ? 16'h0000 : s_reg.lcnt + 16'h0001;
            if (s_reg.lcnt == 16'h0000) begin
               if (s_reg.line == int_start_c) begin
                  s_next.armed = run_c;
                  s_next.integ_all = run_c && !rolling_c;
               end
               if (s_reg.rd_en && s_reg.line < ro_c) begin
                  s_next.row_read = 1'b1;
                  s_next.row_read_addr = {s_reg.roi_y[15:1], 1'b0} +
                                         {s_reg.line[14:0], 1'b0};
                  s_next.msg.first = (s_reg.line == 16'h0000);
                  s_next.msg.last = (s_reg.line == ro_c - 16'h0001);
                  s_next.msg.depth = depth_c;
                  s_next.msg.banks = banks_c;
                  s_next.msg.words = words_c;
                  s_next.tog = !s_reg.tog;
               end
               // Row pair reset ahead of its read by exactly the integration length
               if (rolling_c && rs_c < ro_c &&
                   ((s_reg.line >= int_start_c) ? ((s_reg.line == int_start_c) ? run_c :
                    s_reg.armed) : s_reg.rd_en)) begin
                  s_next.row_reset = 1'b1;
                  s_next.row_reset_addr = {s_reg.roi_y[15:1], 1'b0} + {rs_c[14:0], 1'b0};
               end
            end
            if (line_end_c) begin
               if (s_reg.line >= s_reg.frame_len - 16'h0001) begin
                  s_next.integ_all = 1'b0;
                  if (s_reg.armed) begin
                     s_next.line = 16'h0000;
                     s_next.rd_en = 1'b1;
                     s_next.armed = 1'b0;
                  end else begin
                     s_next.st = SEQ_IDLE;
                     s_next.rd_en = 1'b0;
                  end
               end else begin
                  s_next.line = s_reg.line + 16'h0001;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_reg <= '0;
         s_reg.st <= SEQ_IDLE;
         s_reg.roi_y <= RST_ROI_Y;
         s_reg.roi_h <= RST_ROI_H;
         s_reg.roi_w <= RST_ROI_W;
         s_reg.vertical_blank <= RST_VERTICAL_BLANK;
         s_reg.integ <= RST_INTEG;
         s_reg.mode <= RST_MODE;
         s_reg.cmd <= RST_STATE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign reg_rdata_o = s_reg.rdata;
   assign reg_rvalid_o = s_reg.rvalid;
   assign run_state_o = (s_reg.st == SEQ_RUN);
   assign integ_all_o = s_reg.integ_all;
   assign row_reset_o = s_reg.row_reset;
   assign row_reset_addr_o = s_reg.row_reset_addr;
   assign row_read_o = s_reg.row_read;
   assign row_read_addr_o = s_reg.row_read_addr;

   // ----------------------------------------------------------------
   // Link domain
   // ----------------------------------------------------------------
   // Reset asserts at once and releases on the link clock
   always_ff @(posedge link_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lrst_q <= 2'b11;
      end else begin
         lrst_q <= {lrst_q[0], 1'b0};
      end
   end

   // The message is held for a whole line period, far longer than the toggle
   // takes to cross, so it is sampled stable once the toggle is seen.
   always_comb begin
      logic [13:0] code;
      logic [PIX_W-1:0] word;
      logic [3:0] nb;
      l_next = l_reg;
      code = 14'h0000;
      word = '0;
      nb = (l_reg.msg.banks == BANKS_2) ? 4'h2 : (l_reg.msg.banks == BANKS_4) ? 4'h4 : 4'h8;
      l_next.tog_sync = {l_reg.tog_sync[1:0], s_reg.tog};
      unique case (l_reg.st)
         LNK_IDLE: begin
            if (l_reg.tog_sync[1] ^ l_reg.tog_sync[2]) begin
               l_next.st = LNK_HEAD;
               l_next.cnt = 16'h0000;
               l_next.msg = s_reg.msg;
            end
         end
         LNK_HEAD: begin
            l_next.cnt = l_reg.cnt + 16'h0001;
            if (l_reg.cnt == SYNC_LEN - 16'h0001) begin
               l_next.st = LNK_PIX;
               l_next.cnt = 16'h0000;
            end
         end
         LNK_PIX: begin
            l_next.cnt = l_reg.cnt + 16'h0001;
            if (l_reg.cnt + 16'h0001 >= l_reg.msg.words) begin
               l_next.st = LNK_TAIL;
               l_next.cnt = 16'h0000;
            end
         end
         LNK_TAIL: begin
            l_next.cnt = l_reg.cnt + 16'h0001;
            if (l_reg.cnt == SYNC_LEN - 16'h0001) begin
               l_next.st = LNK_IDLE;
               l_next.cnt = 16'h0000;
            end
         end
      endcase
      l_next.take = (l_next.st == LNK_PIX);
      l_next.valid = (l_reg.st != LNK_IDLE);
      if (l_reg.st == LNK_HEAD) begin
         code = l_reg.msg.first ? CODE_SOF : CODE_SOL;
      end else begin
         code = l_reg.msg.last ? CODE_EOF : CODE_EOL;
      end
      word = (l_reg.cnt == SYNC_LEN - 16'h0001) ? code :
             ((l_reg.cnt == 16'h0000) ? SYNC_LEAD : 14'h0000);
      for (int b = 0; b < NUM_BANKS; b++) begin
         if (l_reg.st == LNK_PIX) begin
            l_next.bank[b] = drive(pix_i[b], l_reg.msg.depth, 4'(b) < nb);
         end else begin
            l_next.bank[b] = drive(word, l_reg.msg.depth,
                                   (l_reg.st != LNK_IDLE) && (4'(b) < nb));
         end
      end
   end

   always_ff @(posedge link_clk_i or posedge rst_i) begin
      if (rst_i) begin
         l_reg <= '0;
      end else if (lrst_q[1]) begin
         l_reg <= '0;
      end else begin
         l_reg <= l_next;
      end
   end

   assign pix_take_o = l_reg.take;
   assign bank_valid_o = l_reg.valid;
   assign bank_o = l_reg.bank;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence head_four;
      (l_reg.st == LNK_HEAD) [*4] ##1 (l_reg.st == LNK_PIX);
   endsequence
   sequence tail_four;
      (l_reg.st == LNK_TAIL) [*4] ##1 (l_reg.st == LNK_IDLE);
   endsequence

   AST_WRITE_ODD: assert property (@(posedge clk_i) disable iff (rst_i)
      reg_req_i.strobe && reg_req_i.addr == ADDR_INTEG |=> s_reg.integ == $past(reg_req_i.wdata))
      else $error("odd address write not stored");
   AST_READ_EVEN: assert property (@(posedge clk_i) disable iff (rst_i)
      reg_req_i.strobe |=> reg_rvalid_o == !$past(reg_req_i.addr[0]))
      else $error("read answer does not follow even address");
   AST_LINE_OVERLAP: assert property (@(posedge clk_i) disable iff (rst_i)
      !s_reg.mode[MODE_SCAN_BIT] ##1 !s_reg.mode[MODE_SCAN_BIT] |->
      s_reg.line_cyc >= $past(tx_c) && s_reg.line_cyc >= $past(rc_c))
      else $error("overlapped line period too short");
   AST_LINE_PIPE: assert property (@(posedge clk_i) disable iff (rst_i)
      s_reg.mode[MODE_SCAN_BIT] |=> s_reg.line_cyc == max16($past(tx_c),
      max16(PIX_READ_CYC, $past(conv_c))))
      else $error("pipelined line period wrong");
   AST_FRAME_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> s_reg.frame_len >= $past(integ_c) && s_reg.frame_len >= $past(need_c))
      else $error("frame length does not cover integration");
   AST_READ_AFTER_INTEG: assert property (@(posedge clk_i) disable iff (rst_i)
      s_reg.st == SEQ_RUN && line_end_c && s_reg.armed &&
      s_reg.line >= s_reg.frame_len - 16'h0001 |=> s_reg.rd_en && s_reg.line == 16'h0000)
      else $error("readout did not start after integration");
   AST_GLOBAL_NO_ROW_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
      !rolling_c |=> !row_reset_o)
      else $error("row reset in global shutter");
   AST_EVEN_ROW: assert property (@(posedge clk_i) disable iff (rst_i)
      row_read_o |-> !row_read_addr_o[0] ##1 !row_read_o)
      else $error("row pair read not even or not single");
   AST_SYNC_HEAD: assert property (@(posedge link_clk_i) disable iff (rst_i)
      $rose(l_reg.st == LNK_HEAD) |-> head_four)
      else $error("start syncs not four words");
   AST_SYNC_TAIL: assert property (@(posedge link_clk_i) disable iff (rst_i)
      $rose(l_reg.st == LNK_TAIL) |-> tail_four)
      else $error("end syncs not four words");
   AST_DEPTH_HIZ: assert property (@(posedge link_clk_i) disable iff (rst_i)
      l_reg.valid && l_reg.msg.depth == DEPTH_10 && $stable(l_reg.msg) |->
      l_reg.bank[0].en == 7'h1f)
      else $error("ten bit mode drives wrong pairs");

endmodule : image_readout_sequencer

// ---- test/pix_source.sv ----
// Pixel source model on the link side of the sequencer.
// Assumes pix_take_i is registered in the link clock domain.
`timescale 1ns/1ps
module pix_source import readout_pkg::*; (
   // Link clock and reset
   input wire logic link_clk_i,
   input wire logic rst_i,
   // Pixel handshake
   input wire logic pix_take_i,
   output logic [NUM_BANKS-1:0][PIX_W-1:0] pix_o
);
   logic [PIX_W-1:0] count_reg;
   // Lines flip while not taken, so stale pixels never look fresh
   always_ff @(posedge link_clk_i or posedge rst_i) begin
      if (rst_i) begin
         count_reg <= '0;
         pix_o <= '0;
      end else if (pix_take_i) begin
         count_reg <= count_reg + 14'h0001;
         for (int b = 0; b < NUM_BANKS; b++) begin
            pix_o[b] <= count_reg + 14'(b);
         end
      end else begin
         pix_o <= ~pix_o;
      end
   end
endmodule : pix_source

// ---- test/tb.sv ----
// Testbench of the readout sequencer: registers, frame start, link words.
// Assumes the pixel source model pix_source on the link side.
`timescale 1ns/1ps
module tb import readout_pkg::*; ;
   logic clk_i = 1'b0, rst_i = 1'b1, link_clk_i = 1'b0, frame_trigger_i = 1'b0;
   reg_req_t reg_req_i = '0;
   logic [15:0] reg_rdata_o, row_reset_addr_o, row_read_addr_o;
   logic reg_rvalid_o, run_state_o, integ_all_o, row_reset_o, row_read_o;
   logic pix_take_o, bank_valid_o;
   logic [NUM_BANKS-1:0][PIX_W-1:0] pix_i;
   bank_out_t [NUM_BANKS-1:0] bank_o;
   int miscompares = 0, checks_done = 0;
   always #10 clk_i = ~clk_i;
   // Link clock starts off phase so the two domains never line up
   initial begin
      #7;
      forever #15 link_clk_i = ~link_clk_i;
   end
   image_readout_sequencer i_dut (.clk_i, .rst_i, .reg_req_i, .reg_rdata_o, .reg_rvalid_o,
      .frame_trigger_i, .run_state_o, .integ_all_o, .row_reset_o, .row_reset_addr_o,
      .row_read_o, .row_read_addr_o, .link_clk_i, .pix_i, .pix_take_o, .bank_valid_o, .bank_o);
   pix_source i_src (.link_clk_i, .rst_i, .pix_take_i(pix_take_o), .pix_o(pix_i));
   task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task end_sim;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   task reg_acc(input logic [15:0] a, input logic [15:0] d);
      @(negedge clk_i) reg_req_i = '{1'b1, a, d};
      @(negedge clk_i) reg_req_i.strobe = 1'b0;
   endtask : reg_acc
   task reg_rd(input string name, input logic [15:0] a, input logic [15:0] exp);
      reg_acc(a, 16'h0000);
      for (int i = 0; i < 2 && reg_rvalid_o !== 1'b1; i++) @(negedge clk_i);
      check(name, reg_rdata_o, exp);
   endtask : reg_rd
   task test_regs;
      reg_rd("integ", ADDR_INTEG - 16'h0001, RST_INTEG);
      reg_rd("mode", ADDR_MODE - 16'h0001, RST_MODE);
      reg_rd("height", ADDR_ROI_H - 16'h0001, RST_ROI_H);
      reg_rd("unmapped", 16'h0002, 16'h0000);
      reg_acc(ADDR_INTEG, 16'h0001);
      reg_rd("integ_wr", ADDR_INTEG - 16'h0001, 16'h0001);
      $display("test regs done");
   endtask : test_regs
   // One short frame: a single row pair of eight columns
   task test_frame(input logic [15:0] mode, input logic [6:0] en0, input logic [6:0] en7);
      reg_acc(ADDR_ROI_H, 16'h0002);
      reg_acc(ADDR_ROI_W, 16'h0008);
      reg_acc(ADDR_MODE, mode);
      reg_acc(ADDR_STATE, RUN_STATE_CODE);
      @(negedge clk_i);
      check("run_state", 16'(run_state_o), 16'h0001);
      for (int i = 0; i < 1000 && row_read_o !== 1'b1; i++) @(negedge clk_i);
      check("row_addr", row_read_addr_o, RST_ROI_Y);
      check("integ_all", 16'(integ_all_o), 16'(mode[1:0] == SHUTTER_GLOBAL));
      check("row_reset", 16'(row_reset_o), 16'(mode[1:0] == SHUTTER_ROLLING));
      reg_acc(ADDR_STATE, RST_STATE);
      for (int i = 0; i < 100 && bank_valid_o !== 1'b1; i++) @(negedge link_clk_i);
      check("en0", 16'(bank_o[0].en), 16'(en0));
      check("en7", 16'(bank_o[7].en), 16'(en7));
      check("lead", 16'(bank_o[0].msb), 16'(en0));
      for (int i = 0; i < 2000 && run_state_o !== 1'b0; i++) @(negedge clk_i);
      check("stopped", 16'(run_state_o), 16'h0000);
      $display("test frame %h done", mode);
   endtask : test_frame
   task test_trigger;
      @(negedge clk_i) frame_trigger_i = 1'b1;
      for (int i = 0; i < 10 && run_state_o !== 1'b1; i++) @(negedge clk_i);
      check("trig_run", 16'(run_state_o), 16'h0001);
      frame_trigger_i = 1'b0;
      for (int i = 0; i < 2000 && run_state_o !== 1'b0; i++) @(negedge clk_i);
      check("trig_stop", 16'(run_state_o), 16'h0000);
      $display("test trigger done");
   endtask : test_trigger
   initial begin
      repeat (8) @(negedge clk_i);
      rst_i = 1'b0;
      test_regs();
      test_frame(16'h0000, 7'h1f, 7'h1f);
      test_frame(16'h0010, 7'h7f, 7'h7f);
      test_frame(16'h0021, 7'h1f, 7'h00);
      test_trigger();
      end_sim();
   end
   // Whole run needs some thousands of cycles
   initial begin
      #1000000;
      miscompares++;
      end_sim();
   end
endmodule : tb
